/* design/dma_status_pkg.sv */
// Package: offsets, bit positions and codes of the DMA status block
package dma_status_pkg;
  localparam logic [7:0] DMA_STATUS_OFFSET = 8'h28;
  localparam logic [7:0] SW_RESET_OFFSET = 8'h00;
  localparam int SW_RESET_BIT = 0;
  localparam int TX_DONE_BIT = 0;
  localparam int TX_STOPPED_BIT = 1;
  localparam int TX_DESC_UNAVAIL_BIT = 2;
  localparam int JABBER_BIT = 3;
  localparam int TX_UNDERFLOW_BIT = 5;
  localparam int RX_DONE_BIT = 6;
  localparam int RX_DESC_UNAVAIL_BIT = 7;
  localparam int RX_STOPPED_BIT = 8;
  localparam int RX_WATCHDOG_BIT = 9;
  localparam int TIMER_EXPIRED_BIT = 11;
  localparam int FATAL_BUS_ERROR_BIT = 13;
  localparam int ABNORMAL_SUMMARY_BIT = 15;
  localparam int NORMAL_SUMMARY_BIT = 16;
  localparam int RX_STATE_LSB = 17;
  localparam int TX_STATE_LSB = 20;
  localparam int BUS_ERROR_TYPE_LSB = 23;
  localparam logic [31:0] DMA_STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] EVENT_MASK = 32'h0000_2bef;
  localparam logic [2:0] TX_STOP = 3'h0;
  localparam logic [2:0] TX_READ_DESC = 3'h1;
  localparam logic [2:0] TX_TRANSMIT = 3'h2;
  localparam logic [2:0] TX_FIFO_FILL = 3'h3;
  localparam logic [2:0] TX_SUSPEND = 3'h6;
  localparam logic [2:0] TX_WRITE_DESC = 3'h7;
  localparam logic [2:0] RX_STOP = 3'h0;
  localparam logic [2:0] RX_READ_DESC = 3'h1;
  localparam logic [2:0] RX_CHECK = 3'h2;
  localparam logic [2:0] RX_WAIT = 3'h3;
  localparam logic [2:0] RX_SUSPEND = 3'h4;
  localparam logic [2:0] RX_WRITE_DESC = 3'h5;
  localparam logic [2:0] RX_FLUSH = 3'h6;
  localparam logic [2:0] RX_DRAIN = 3'h7;
  localparam logic [2:0] BET_PARITY = 3'h0;
  localparam logic [2:0] BET_MASTER_ABORT = 3'h1;
  localparam logic [2:0] BET_TARGET_ABORT = 3'h2;
endpackage

/* design/state_code_map.sv */
// Module: maps one-hot process activity to a three-bit state code
`timescale 1ns/1ps
`default_nettype none
module state_code_map (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] act,
  output logic [2:0] code
);
  logic [2:0] code_reg;
  logic [2:0] code_next;
  always_comb begin
    code_next = 3'h0;
    // Lowest active index from 1 up wins; bit 0 alone or idle means stop
    for (int i = 7; i >= 1; i = i - 1) begin
      if (act[i]) begin
        code_next = i[2:0];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      code_reg <= 3'h0;
    end else begin
      code_reg <= code_next;
    end
  end
  assign code = code_reg;
endmodule
`default_nettype wire

/* design/dma_status_reporting.sv */
// Module: DMA status register, summary flags and fatal bus error lockout
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dma_status_reporting (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic [2:0] tx_state,
  input wire logic [2:0] rx_state,
  input wire logic tx_done_event,
  input wire logic tx_desc_unavail_event,
  input wire logic jabber_event,
  input wire logic tx_underflow_event,
  input wire logic rx_done_event,
  input wire logic rx_desc_unavail_event,
  input wire logic timer_expired_event,
  input wire logic rx_watchdog_event,
  input wire logic parity_error,
  input wire logic master_abort,
  input wire logic target_abort,
  input wire logic bus_request,
  output logic bus_grant_enable,
  output logic soft_reset
);
  typedef struct packed {
    logic [31:0] flags;
    logic [2:0] bus_error_type;
    logic [2:0] rx_prev;
    logic bus_locked;
    logic soft_reset;
    logic [31:0] rdata;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic [2:0] tx_code;
  logic [2:0] rx_code;
  logic [7:0] tx_act;
  logic [7:0] rx_act;
  logic [31:0] set_vec;
  logic [31:0] status_view;

  function automatic logic [7:0] onehot3(input logic [2:0] c);
    onehot3 = 8'h01 << c;
  endfunction

  // Registered code keeps the field glitch free for software reads
  always_comb begin
    tx_act = onehot3(tx_state);
    // Reserved codes are never reported
    if (tx_state == 3'h4 || tx_state == 3'h5) begin
      tx_act = onehot3(dma_status_pkg::TX_STOP);
    end
    rx_act = onehot3(rx_state);
  end

  state_code_map tx_map (
    .clk(clk),
    .rst_n(rst_n),
    .act(tx_act),
    .code(tx_code)
  );

  state_code_map rx_map (
    .clk(clk),
    .rst_n(rst_n),
    .act(rx_act),
    .code(rx_code)
  );

  always_comb begin
    set_vec = 32'h0;
    set_vec[dma_status_pkg::TX_DONE_BIT] = tx_done_event;
    set_vec[dma_status_pkg::TX_STOPPED_BIT] = (tx_code == dma_status_pkg::TX_STOP);
    set_vec[dma_status_pkg::TX_DESC_UNAVAIL_BIT] = tx_desc_unavail_event;
    set_vec[dma_status_pkg::JABBER_BIT] = jabber_event;
    set_vec[dma_status_pkg::TX_UNDERFLOW_BIT] = tx_underflow_event;
    set_vec[dma_status_pkg::RX_DONE_BIT] = rx_done_event;
    set_vec[dma_status_pkg::RX_DESC_UNAVAIL_BIT] = rx_desc_unavail_event;
    set_vec[dma_status_pkg::RX_STOPPED_BIT] = (rx_code == dma_status_pkg::RX_STOP) &&
                                              (st_reg.rx_prev != dma_status_pkg::RX_STOP);
    set_vec[dma_status_pkg::RX_WATCHDOG_BIT] = rx_watchdog_event;
    set_vec[dma_status_pkg::TIMER_EXPIRED_BIT] = timer_expired_event;
    set_vec[dma_status_pkg::FATAL_BUS_ERROR_BIT] = parity_error | master_abort |
                                                   target_abort;
  end

  // Summaries are combinational views of the latched flags
  always_comb begin
    status_view = st_reg.flags & dma_status_pkg::EVENT_MASK;
    status_view[dma_status_pkg::NORMAL_SUMMARY_BIT] =
      st_reg.flags[dma_status_pkg::TX_DONE_BIT] |
      st_reg.flags[dma_status_pkg::TX_DESC_UNAVAIL_BIT] |
      st_reg.flags[dma_status_pkg::RX_DONE_BIT];
    status_view[dma_status_pkg::ABNORMAL_SUMMARY_BIT] =
      st_reg.flags[dma_status_pkg::TX_STOPPED_BIT] |
      st_reg.flags[dma_status_pkg::JABBER_BIT] |
      st_reg.flags[dma_status_pkg::TX_UNDERFLOW_BIT] |
      st_reg.flags[dma_status_pkg::RX_DESC_UNAVAIL_BIT] |
      st_reg.flags[dma_status_pkg::RX_STOPPED_BIT] |
      st_reg.flags[dma_status_pkg::RX_WATCHDOG_BIT] |
      st_reg.flags[dma_status_pkg::TIMER_EXPIRED_BIT] |
      st_reg.flags[dma_status_pkg::FATAL_BUS_ERROR_BIT];
    status_view[dma_status_pkg::RX_STATE_LSB +: 3] = rx_code;
    status_view[dma_status_pkg::TX_STATE_LSB +: 3] = tx_code;
    status_view[dma_status_pkg::BUS_ERROR_TYPE_LSB +: 3] = st_reg.bus_error_type;
  end

  always_comb begin
    st_next = st_reg;
    st_next.rx_prev = rx_code;
    st_next.soft_reset = 1'b0;
    st_next.rdata = 32'h0;
    // Write-one clears; a same-cycle event wins over the clear
    if (reg_write && reg_addr == dma_status_pkg::DMA_STATUS_OFFSET) begin
      st_next.flags = st_reg.flags & ~(reg_wdata & dma_status_pkg::EVENT_MASK);
    end
    st_next.flags = (st_next.flags | set_vec) & dma_status_pkg::EVENT_MASK;
    // First cause is kept; later errors must not overwrite it
    if (!st_reg.bus_locked) begin
      if (parity_error) begin
        st_next.bus_error_type = dma_status_pkg::BET_PARITY;
      end else if (master_abort) begin
        st_next.bus_error_type = dma_status_pkg::BET_MASTER_ABORT;
      end else if (target_abort) begin
        st_next.bus_error_type = dma_status_pkg::BET_TARGET_ABORT;
      end
    end
    if (set_vec[dma_status_pkg::FATAL_BUS_ERROR_BIT]) begin
      st_next.bus_locked = 1'b1;
    end
    if (reg_write && reg_addr == dma_status_pkg::SW_RESET_OFFSET &&
        reg_wdata[dma_status_pkg::SW_RESET_BIT]) begin
      st_next.soft_reset = 1'b1;
      st_next.bus_locked = 1'b0;
      st_next.flags = 32'h0;
      st_next.bus_error_type = 3'h0;
    end
    if (reg_read) begin
      case (reg_addr)
        dma_status_pkg::DMA_STATUS_OFFSET: begin
          st_next.rdata = status_view;
        end
        dma_status_pkg::SW_RESET_OFFSET: begin
          st_next.rdata = 32'h0;
        end
        default: begin
          st_next.rdata = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg.flags <= dma_status_pkg::DMA_STATUS_RESET;
      st_reg.bus_error_type <= 3'h0;
      st_reg.rx_prev <= 3'h0;
      st_reg.bus_locked <= 1'b0;
      st_reg.soft_reset <= 1'b0;
      st_reg.rdata <= 32'h0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  // Gate blocks new requests in the very cycle the error arrives
  assign bus_grant_enable = bus_request & ~st_reg.bus_locked &
                            ~set_vec[dma_status_pkg::FATAL_BUS_ERROR_BIT];
  assign soft_reset = st_reg.soft_reset;
endmodule
`default_nettype wire

/* bench/dma_status_reporting_chk.sv */
// Checker: port assertions for the DMA status block
`timescale 1ns/1ps
`default_nettype none
module dma_status_reporting_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic timer_expired_event,
  input wire logic rx_watchdog_event,
  input wire logic parity_error,
  input wire logic master_abort,
  input wire logic target_abort,
  input wire logic bus_grant_enable,
  input wire logic soft_reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic st_rd;
  logic err;
  assign err = parity_error | master_abort | target_abort;
  // Status read one edge ago, so rdata holds the word now
  always_ff @(posedge clk) begin
    st_rd <= reg_read && reg_addr == dma_status_pkg::DMA_STATUS_OFFSET;
  end
  AST_RDATA_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  AST_RSVD_ZERO: assert property ($past(reg_read) |-> (reg_rdata & 32'hfc00_5410) == 32'h0)
    else $error("reserved bit read as one");
  AST_NORMAL_SUM: assert property (st_rd |-> reg_rdata[16] == |(reg_rdata & 32'h0000_0045))
    else $error("normal summary mismatch");
  AST_ABN_SUM: assert property (st_rd |-> reg_rdata[15] == |(reg_rdata & 32'h0000_2baa))
    else $error("abnormal summary mismatch");
  AST_ERR_BLOCK: assert property (err |-> !bus_grant_enable)
    else $error("bus granted during bus error");
  AST_LOCK_HOLD: assert property (parity_error ##1 !soft_reset [*8] |-> !bus_grant_enable)
    else $error("bus lock released without reset");
  AST_SW_RESET: assert property (reg_write && reg_addr == dma_status_pkg::SW_RESET_OFFSET && reg_wdata[0] |=> soft_reset)
    else $error("software reset pulse missing");
  AST_FATAL_FLAG: assert property (st_rd && $past(parity_error, 2) |-> reg_rdata[13] && reg_rdata[25:23] == 3'h0)
    else $error("fatal flag or type wrong");
  AST_TIMER_FLAG: assert property (st_rd && $past(timer_expired_event, 2) |-> reg_rdata[11])
    else $error("timer flag not latched");
  AST_WDOG_FLAG: assert property (st_rd && $past(rx_watchdog_event, 2) |-> reg_rdata[9])
    else $error("watchdog flag not latched");
  cover property (st_rd && reg_rdata[13]);
  cover property (soft_reset);
  cover property (err);
endmodule
`default_nettype wire

/* bench/dma_status_reporting_tb.sv */
// Testbench: DMA status block reads, flags and bus lockout
`timescale 1ns/1ps
`default_nettype none
module dma_status_reporting_tb;
  typedef struct packed {logic [2:0] tx; logic [2:0] rx; logic [7:0] ev; logic [31:0] exp;} row_t;
  localparam logic [7:0] ST = dma_status_pkg::DMA_STATUS_OFFSET;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic [2:0] tx_state = 3'h0;
  logic [2:0] rx_state = 3'h1;
  logic [7:0] ev = 8'h00;
  logic [2:0] err = 3'h0;
  logic bus_request = 1'b0;
  logic bus_grant_enable;
  logic soft_reset;
  logic [31:0] d;
  int fail_count = 0;
  int tests_run = 0;
  // Rx never enters stop here: a stop entry would be cleared before the read
  row_t rows [7] = '{'{3'h0, 3'h1, 8'h00, 32'h0002_8002}, '{3'h1, 3'h2, 8'h01, 32'h0015_0001},
    '{3'h2, 3'h3, 8'h02, 32'h0027_0004}, '{3'h3, 3'h4, 8'h04, 32'h0038_8008},
    '{3'h6, 3'h5, 8'h08, 32'h006a_8020}, '{3'h7, 3'h6, 8'h30, 32'h007d_80c0},
    '{3'h1, 3'h7, 8'hc0, 32'h001e_8a00}};
  always #12.5 clk = ~clk;
  dma_status_reporting dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .tx_state(tx_state),
    .rx_state(rx_state), .tx_done_event(ev[0]), .tx_desc_unavail_event(ev[1]),
    .jabber_event(ev[2]), .tx_underflow_event(ev[3]), .rx_done_event(ev[4]),
    .rx_desc_unavail_event(ev[5]), .timer_expired_event(ev[6]), .rx_watchdog_event(ev[7]),
    .parity_error(err[0]), .master_abort(err[1]), .target_abort(err[2]),
    .bus_request(bus_request), .bus_grant_enable(bus_grant_enable), .soft_reset(soft_reset));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic final_report;
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #50000;
    fail_count++;
    final_report;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ST);
    chk(d, 32'h0002_8002);
    $display("reset test done");
    for (int i = 0; i < 7; i++) begin
      tx_state <= rows[i].tx;
      rx_state <= rows[i].rx;
      repeat (3) @(posedge clk);
      wr(ST, dma_status_pkg::EVENT_MASK);
      ev <= rows[i].ev;
      @(posedge clk);
      ev <= 8'h00;
      rd(ST);
      chk(d, rows[i].exp);
    end
    // Unused transmit code must report as stop
    tx_state <= 3'h5;
    repeat (3) @(posedge clk);
    rd(ST);
    chk(d, 32'h000e_8a02);
    tx_state <= 3'h1;
    repeat (2) @(posedge clk);
    $display("row tests done");
    wr(ST, dma_status_pkg::EVENT_MASK);
    rx_state <= 3'h0;
    repeat (3) @(posedge clk);
    rd(ST);
    chk(d, 32'h0010_8100);
    wr(ST, 32'h0000_0100);
    rd(ST);
    chk(d, 32'h0010_0000);
    ev <= 8'h40;
    @(posedge clk);
    ev <= 8'h00;
    wr(ST, 32'hffff_f7ff);
    rd(ST);
    chk(d, 32'h0010_8800);
    rd(8'h04);
    chk(d, 32'h0);
    wr(ST, 32'h0000_0800);
    $display("latch tests done");
    bus_request <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      #1 chk({31'h0, bus_grant_enable}, 32'h1);
      @(posedge clk);
      err <= 3'h1 << i;
      @(posedge clk);
      err <= 3'h0;
      rd(ST);
      chk(d, 32'h0010_a000 | (32'(i) << 23));
      repeat (8) @(posedge clk);
      #1 chk({31'h0, bus_grant_enable}, 32'h0);
      @(posedge clk);
      reg_addr <= dma_status_pkg::SW_RESET_OFFSET;
      reg_wdata <= 32'h1;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
      #1 chk({31'h0, soft_reset}, 32'h1);
      @(posedge clk);
    end
    rd(ST);
    chk(d, 32'h0010_0000);
    $display("bus error tests done");
    final_report;
  end
endmodule
bind dma_status_reporting dma_status_reporting_chk chk_i (
  .clk(clk),
  .rst_n(rst_n),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_write(reg_write),
  .reg_read(reg_read),
  .reg_rdata(reg_rdata),
  .timer_expired_event(timer_expired_event),
  .rx_watchdog_event(rx_watchdog_event),
  .parity_error(parity_error),
  .master_abort(master_abort),
  .target_abort(target_abort),
  .bus_grant_enable(bus_grant_enable),
  .soft_reset(soft_reset)
);
`default_nettype wire
